// >>> hw/dat_regs.sv
// discharge alert threshold registers, control decode and throttle alert
// What this block does
// - threshold written by word command 0x48
// - threshold bits 13:8 weigh 256mA upward
// - only bits 13:8 stored, rest ignored
// - written codes above 110010 clamp to 110010
// - threshold resets to 0x1000
// - threshold reads back as stored
// - alert asserts after selected debounce time
// - alert stays on for selected minimum time
// - battery-only low power uses table threshold
// - battery-only detection needs power monitor enabled
// - info bit 15 shows comparator reference active
// - adapter present keeps reference always active
// - debounce shared; low voltage fixed 10us
// - commands 0x39 0x3C 0x3D reach config regs
// - commands 0x4C 0x4E reach config regs
// - bits 15:13 buck offset, revision scaled
// - bits 12:10 boost offset
`timescale 1ns/1ps
`include "dat_params.svh"
module dat_regs #(
  parameter logic [6:0]  SMB_ADDR   = `DAT_SMB_ADDR,
  parameter int unsigned DEB_US [4] = '{10, 50, 100, 500},
  parameter int unsigned HOLD_US[8] = '{100, 200, 500, 1000, 2000, 5000, 10000, 20000}
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic [15:0] discharge_ma,
  input  wire logic        adapter_present,
  input  wire logic        adapter_overcurrent,
  input  wire logic        low_sys_voltage,
  input  wire logic        low_power_mode,
  input  wire logic        system_power_monitor_en,
  input  wire logic        silicon_revision_b,
  input  wire logic        throttle_alert_n_i,
  output logic             throttle_alert_n_o,
  output logic             throttle_alert_n_oe,
  output logic [15:0]      active_threshold_ma,
  output logic             comparator_ref_active,
  output logic [4:0]       buck_offset_half_mv,
  output logic [4:0]       boost_offset_half_mv
);
  import dat_pkg::*;

  localparam int unsigned NSRC = 3;

  // round up: a debounce or hold is a least time
  function automatic dat_cnt_t to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + `DAT_CLK_NS - 1) / `DAT_CLK_NS;
    if (c == 0) c = 1;
    return dat_cnt_t'(c);
  endfunction

  // signed offset in half millivolt units; revision b doubles the step
  function automatic logic [4:0] ofs_code(input logic [2:0] code,
                                          input logic       rev_b);
    logic [4:0] ext;
    ext = {{2{code[2]}}, code};
    return rev_b ? {ext[3:0], 1'b0} : ext;
  endfunction

  dat_regs_t   r_q;
  dat_regs_t   r_d;
  dat_wr_t     wr;
  logic [7:0]  rd_cmd;
  logic [15:0] rd_data;
  logic [5:0]  thr_field;
  logic [15:0] lp_thr;
  logic [15:0] thr_now;
  logic        ref_now;
  dat_cnt_t    deb_lut  [4];
  dat_cnt_t    hold_lut [8];
  dat_cnt_t    deb_sel;
  dat_cnt_t    hold_sel;
  dat_cnt_t    deb_v    [NSRC];
  logic        cond_v   [NSRC];
  logic [NSRC-1:0] alert_v;

  dat_smbus_slave #(
    .ADDR    (SMB_ADDR)
  ) u_slave (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .sda_o   (sda_o),
    .sda_oe  (sda_oe),
    .wr      (wr),
    .rd_cmd  (rd_cmd),
    .rd_data (rd_data)
  );

  for (genvar g = 0; g < 4; g++) begin : g_deb
    assign deb_lut[g] = to_cyc(DEB_US[g] * `DAT_NS_PER_US);
  end
  for (genvar g = 0; g < 8; g++) begin : g_hold
    assign hold_lut[g] = to_cyc(HOLD_US[g] * `DAT_NS_PER_US);
  end

  assign deb_sel  = deb_lut[r_q.cfg2[`DAT_DEB_HI:`DAT_DEB_LO]];
  assign hold_sel = hold_lut[r_q.cfg2[`DAT_DUR_HI:`DAT_DUR_LO]];

  // clamp: values above the top code store the top code
  assign thr_field = (wr.data[`DAT_THR_HI:`DAT_THR_LO] > `DAT_THR_MAX) ?
                     `DAT_THR_MAX : wr.data[`DAT_THR_HI:`DAT_THR_LO];

  always_comb begin
    case (r_q.cfg0[`DAT_LP_HI:`DAT_LP_LO])
      2'h0:    lp_thr = `DAT_LP_MA0;
      2'h1:    lp_thr = `DAT_LP_MA1;
      2'h2:    lp_thr = `DAT_LP_MA2;
      default: lp_thr = `DAT_LP_MA3;
    endcase
  end

  // reference is forced on with an adapter, else follows the monitor
  assign ref_now = adapter_present | system_power_monitor_en;
  // bits 13:8 at weight 256 make the register value itself the mA figure
  assign thr_now = (~adapter_present & low_power_mode) ? lp_thr : r_q.thr;

  always_comb begin
    r_d           = r_q;
    r_d.ref_on    = ref_now;
    r_d.thr_sel   = thr_now;
    r_d.dc_hit    = ref_now & (discharge_ma > thr_now);
    r_d.drive     = |alert_v;
    r_d.buck_ofs  = ofs_code(r_q.cfg0[`DAT_BUCK_HI:`DAT_BUCK_LO],
                             silicon_revision_b);
    r_d.boost_ofs = ofs_code(r_q.cfg0[`DAT_BOOST_HI:`DAT_BOOST_LO],
                             1'b0);
    if (wr.valid) begin
      case (wr.cmd)
        `DAT_CMD_CFG0: r_d.cfg0 = wr.data;
        `DAT_CMD_CFG1: r_d.cfg1 = wr.data;
        `DAT_CMD_CFG2: r_d.cfg2 = wr.data;
        `DAT_CMD_CFG3: r_d.cfg3 = wr.data;
        `DAT_CMD_CFG4: r_d.cfg4 = wr.data;
        `DAT_CMD_THR: begin
          r_d.thr = '0;
          r_d.thr[`DAT_THR_HI:`DAT_THR_LO] = thr_field;
        end
        default: ;
      endcase
    end
  end

  // unknown commands read as zero; writes to them are dropped
  always_comb begin
    rd_data = `DAT_RD_NONE;
    case (rd_cmd)
      `DAT_CMD_CFG0: rd_data = r_q.cfg0;
      `DAT_CMD_CFG1: rd_data = r_q.cfg1;
      `DAT_CMD_CFG2: rd_data = r_q.cfg2;
      `DAT_CMD_CFG3: rd_data = r_q.cfg3;
      `DAT_CMD_CFG4: rd_data = r_q.cfg4;
      `DAT_CMD_THR:  rd_data = r_q.thr;
      `DAT_CMD_INFO: begin
        rd_data[`DAT_INFO_REF] = r_q.ref_on;
        rd_data[`DAT_INFO_PIN] = throttle_alert_n_i;
      end
      default: ;
    endcase
  end

  // source 0 discharge, 1 adapter, 2 low system voltage
  assign cond_v[0] = r_q.dc_hit;
  assign cond_v[1] = adapter_overcurrent;
  assign cond_v[2] = low_sys_voltage;
  assign deb_v[0]  = deb_sel;
  assign deb_v[1]  = deb_sel;
  assign deb_v[2]  = to_cyc(`DAT_LSV_DEB_NS);

  for (genvar g = 0; g < NSRC; g++) begin : g_src
    dat_alert_timer u_tmr (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .cond     (cond_v[g]),
      .deb_cyc  (deb_v[g]),
      .hold_cyc (hold_sel),
      .alert    (alert_v[g])
    );
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_q      <= '0;
      r_q.cfg0 <= `DAT_CFG_RST;
      r_q.cfg1 <= `DAT_CFG_RST;
      r_q.cfg2 <= `DAT_CFG_RST;
      r_q.cfg3 <= `DAT_CFG_RST;
      r_q.cfg4 <= `DAT_CFG_RST;
      r_q.thr  <= `DAT_THR_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // open drain: only ever pulls low
  assign throttle_alert_n_o    = 1'b0;
  assign throttle_alert_n_oe   = r_q.drive;
  assign active_threshold_ma   = r_q.thr_sel;
  assign comparator_ref_active = r_q.ref_on;
  assign buck_offset_half_mv   = r_q.buck_ofs;
  assign boost_offset_half_mv  = r_q.boost_ofs;
endmodule

// >>> hw/dat_params.svh
// command codes, field positions, reset values and timing constants
`ifndef DAT_PARAMS_SVH
`define DAT_PARAMS_SVH

`define DAT_CMD_CFG0    8'h39
`define DAT_CMD_CFG1    8'h3C
`define DAT_CMD_CFG2    8'h3D
`define DAT_CMD_INFO    8'h3A
`define DAT_CMD_THR     8'h48
`define DAT_CMD_CFG3    8'h4C
`define DAT_CMD_CFG4    8'h4E

`define DAT_THR_RST     16'h1000
`define DAT_CFG_RST     16'h0000
`define DAT_RD_NONE     16'h0000
`define DAT_THR_LO      8
`define DAT_THR_HI      13
`define DAT_THR_MAX     6'h32

`define DAT_LP_LO       3
`define DAT_LP_HI       4
`define DAT_LP_MA0      16'h2EE0
`define DAT_LP_MA1      16'h2710
`define DAT_LP_MA2      16'h1F40
`define DAT_LP_MA3      16'h1770

`define DAT_BUCK_LO     13
`define DAT_BUCK_HI     15
`define DAT_BOOST_LO    10
`define DAT_BOOST_HI    12
`define DAT_DEB_LO      9
`define DAT_DEB_HI      10
`define DAT_DUR_LO      6
`define DAT_DUR_HI      8

`define DAT_INFO_REF    15
`define DAT_INFO_PIN    14

`define DAT_CLK_NS      10
`define DAT_NS_PER_US   1000
`define DAT_LSV_DEB_NS  10000
`define DAT_SMB_ADDR    7'h5A

`endif

// >>> hw/dat_pkg.sv
// shared types of the discharge alert threshold block
package dat_pkg;

  typedef logic [23:0] dat_cnt_t;

  typedef enum logic [3:0] {
    SB_IDLE, SB_ADDR, SB_ACKA, SB_CMD, SB_ACKC, SB_WDAT, SB_ACKW, SB_TX, SB_RACK
  } dat_sb_state_t;

  typedef enum logic [1:0] {TM_IDLE, TM_DEB, TM_HOLD, TM_REL} dat_tm_state_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  cmd;
    logic [15:0] data;
  } dat_wr_t;

  typedef struct packed {
    dat_sb_state_t st;
    logic          scl;
    logic          sda;
    logic [7:0]    sh;
    logic [2:0]    bits;
    logic          full;
    logic          hi;
    logic          rnw;
    logic          oe;
    logic          wr_valid;
    logic [7:0]    cmd;
    logic [15:0]   data;
    logic [15:0]   tx;
  } dat_slave_t;

  typedef struct packed {
    dat_tm_state_t st;
    dat_cnt_t      cnt;
    logic          alert;
  } dat_timer_t;

  typedef struct packed {
    logic [15:0] cfg0;
    logic [15:0] cfg1;
    logic [15:0] cfg2;
    logic [15:0] cfg3;
    logic [15:0] cfg4;
    logic [15:0] thr;
    logic [15:0] thr_sel;
    logic        ref_on;
    logic        dc_hit;
    logic        drive;
    logic [4:0]  buck_ofs;
    logic [4:0]  boost_ofs;
  } dat_regs_t;

endpackage

// >>> hw/dat_smbus_slave.sv
// smbus word slave: write-word and read-word with repeated start
`timescale 1ns/1ps
`include "dat_params.svh"
module dat_smbus_slave #(
  parameter logic [6:0] ADDR = `DAT_SMB_ADDR  // arbitrary default address
) (
  input  wire logic            sys_clk,
  input  wire logic            sys_rst,
  input  wire logic            scl_i,
  input  wire logic            sda_i,
  output logic                 sda_o,
  output logic                 sda_oe,
  output dat_pkg::dat_wr_t     wr,
  output logic [7:0]           rd_cmd,
  input  wire logic [15:0]     rd_data
);
  import dat_pkg::*;

  dat_slave_t s_q;
  dat_slave_t s_d;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;

  assign rise  = scl_i & ~s_q.scl;
  assign fall  = ~scl_i & s_q.scl;
  assign start = scl_i & s_q.scl & s_q.sda & ~sda_i;
  assign stop  = scl_i & s_q.scl & ~s_q.sda & sda_i;

  always_comb begin
    s_d          = s_q;
    s_d.scl      = scl_i;
    s_d.sda      = sda_i;
    s_d.wr_valid = 1'b0;
    if (start) begin
      s_d.st   = SB_ADDR;
      s_d.bits = 3'h0;
      s_d.full = 1'b0;
      s_d.hi   = 1'b0;
      s_d.oe   = 1'b0;
    end else if (stop) begin
      s_d.st = SB_IDLE;
      s_d.oe = 1'b0;
    end else if (rise) begin
      case (s_q.st)
        SB_ADDR, SB_CMD, SB_WDAT: begin
          s_d.sh   = {s_q.sh[6:0], sda_i};
          s_d.bits = s_q.bits + 3'h1;
          s_d.full = (s_q.bits == 3'h7);
        end
        SB_RACK: if (sda_i) s_d.st = SB_IDLE;  // host nack ends the read
        default: ;
      endcase
    end else if (fall) begin
      case (s_q.st)
        SB_ADDR: if (s_q.full) begin
          s_d.full = 1'b0;
          if (s_q.sh[7:1] == ADDR) begin
            s_d.st  = SB_ACKA;
            s_d.oe  = 1'b1;
            s_d.rnw = s_q.sh[0];
          end else begin
            s_d.st = SB_IDLE;
          end
        end
        SB_CMD: if (s_q.full) begin
          s_d.full = 1'b0;
          s_d.cmd  = s_q.sh;
          s_d.st   = SB_ACKC;
          s_d.oe   = 1'b1;
        end
        SB_WDAT: if (s_q.full) begin
          s_d.full = 1'b0;
          s_d.st   = SB_ACKW;
          s_d.oe   = 1'b1;
          if (!s_q.hi) begin
            s_d.data[7:0] = s_q.sh;
            s_d.hi        = 1'b1;
          end else begin
            s_d.data[15:8] = s_q.sh;
            s_d.hi         = 1'b0;
            s_d.wr_valid   = 1'b1;
          end
        end
        SB_ACKA: begin
          s_d.bits = 3'h0;
          s_d.hi   = 1'b0;
          if (s_q.rnw) begin
            s_d.tx = rd_data;
            s_d.sh = rd_data[7:0];
            s_d.oe = ~rd_data[7];
            s_d.st = SB_TX;
          end else begin
            s_d.oe = 1'b0;
            s_d.st = SB_CMD;
          end
        end
        SB_ACKC: begin
          s_d.oe = 1'b0;
          s_d.st = SB_WDAT;
        end
        SB_ACKW: begin
          s_d.oe = 1'b0;
          s_d.st = s_q.hi ? SB_WDAT : SB_IDLE;
        end
        SB_TX: begin
          if (s_q.bits == 3'h7) begin
            s_d.oe = 1'b0;
            s_d.st = SB_RACK;
          end else begin
            s_d.sh   = {s_q.sh[6:0], 1'b0};
            s_d.oe   = ~s_q.sh[6];
            s_d.bits = s_q.bits + 3'h1;
          end
        end
        SB_RACK: begin
          // low byte first; bytes past the word read as 0x80
          s_d.sh   = s_q.hi ? 8'h00 : s_q.tx[15:8];
          s_d.oe   = ~s_q.hi & ~s_q.tx[15];
          s_d.hi   = 1'b1;
          s_d.bits = 3'h0;
          s_d.st   = SB_TX;
        end
        default: s_d.st = SB_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q     <= '0;
      s_q.scl <= 1'b1;
      s_q.sda <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe   = s_q.oe;
  assign wr.valid = s_q.wr_valid;
  assign wr.cmd   = s_q.cmd;
  assign wr.data  = s_q.data;
  assign rd_cmd   = s_q.cmd;
endmodule

// >>> hw/dat_alert_timer.sv
// debounce then minimum-hold latch for one alert source
`timescale 1ns/1ps
module dat_alert_timer (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              cond,
  input  wire dat_pkg::dat_cnt_t deb_cyc,
  input  wire dat_pkg::dat_cnt_t hold_cyc,
  output logic                   alert
);
  import dat_pkg::*;

  dat_timer_t t_q;
  dat_timer_t t_d;

  always_comb begin
    t_d = t_q;
    case (t_q.st)
      TM_IDLE: if (cond) begin
        t_d.st  = TM_DEB;
        t_d.cnt = '0;
      end
      TM_DEB: begin
        // a glitch shorter than the debounce restarts the wait
        if (!cond) begin
          t_d.st = TM_IDLE;
        end else if (t_q.cnt + 24'h1 >= deb_cyc) begin
          t_d.st    = TM_HOLD;
          t_d.cnt   = '0;
          t_d.alert = 1'b1;
        end else begin
          t_d.cnt = t_q.cnt + 24'h1;
        end
      end
      TM_HOLD: begin
        if (t_q.cnt + 24'h1 >= hold_cyc) t_d.st = TM_REL;
        else t_d.cnt = t_q.cnt + 24'h1;
      end
      TM_REL: if (!cond) begin
        t_d.st    = TM_IDLE;
        t_d.alert = 1'b0;
      end
      default: t_d.st = TM_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) t_q <= '0;
    else t_q <= t_d;
  end

  assign alert = t_q.alert;
endmodule

// >>> verification/dat_regs_asserts.sv
// port-level checker of threshold, reference and throttle alert timing
`timescale 1ns/1ps
module dat_regs_asserts #(
  parameter int unsigned DEB_US [4] = '{10, 50, 100, 500},
  parameter int unsigned HOLD_US[8] = '{100, 200, 500, 1000, 2000, 5000, 10000, 20000}
) (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [15:0] discharge_ma,
  input wire logic        adapter_present,
  input wire logic        adapter_overcurrent,
  input wire logic        low_sys_voltage,
  input wire logic        low_power_mode,
  input wire logic        system_power_monitor_en,
  input wire logic        throttle_alert_n_oe,
  input wire logic [15:0] active_threshold_ma,
  input wire logic        comparator_ref_active
);
  // 100 cycles per microsecond; tables are taken as ascending
  localparam int DEB_MIN  = DEB_US[0] * 100;
  localparam int HOLD_MIN = HOLD_US[0] * 100;
  localparam int HOLD_MAX = HOLD_US[7] * 100;
  logic [23:0] run_q;
  logic [23:0] on_q;
  logic [23:0] idle_q;
  logic        cond;
  assign cond = ((discharge_ma > active_threshold_ma) && comparator_ref_active)
                || adapter_overcurrent || low_sys_voltage;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_q  <= '0;
      on_q   <= '0;
      idle_q <= '0;
    end else begin
      run_q  <= cond ? run_q + 24'd1 : '0;
      on_q   <= throttle_alert_n_oe ? on_q + 24'd1 : '0;
      idle_q <= cond ? '0 : idle_q + 24'd1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_thr_cap: assert property (active_threshold_ma <= 16'd12800)
    else $error("threshold above clamp");
  a_thr_grain: assert property ($past(adapter_present) && !$past(sys_rst) |->
    active_threshold_ma[7:0] == 8'h00 && active_threshold_ma[15:14] == 2'b00)
    else $error("threshold has unused bits set");
  a_lp_table: assert property ($past(!adapter_present && low_power_mode) && !$past(sys_rst) |->
    active_threshold_ma inside {16'd12000, 16'd10000, 16'd8000, 16'd6000})
    else $error("low power threshold not from table");
  a_ref_track: assert property (!$past(sys_rst) |->
    comparator_ref_active == $past(adapter_present || system_power_monitor_en))
    else $error("reference flag wrong");
  a_ref_adapter: assert property (adapter_present ##1 adapter_present |-> comparator_ref_active)
    else $error("reference off with adapter");
  // margin of four for the registered condition path
  a_alert_cause: assert property ($rose(throttle_alert_n_oe) |-> run_q >= DEB_MIN - 4)
    else $error("alert before debounce");
  a_hold_min: assert property ($fell(throttle_alert_n_oe) |-> on_q >= HOLD_MIN)
    else $error("alert released too early");
  a_alert_release: assert property (idle_q > HOLD_MAX + 8 |-> !throttle_alert_n_oe)
    else $error("alert stuck");
  c_rise: cover property ($rose(throttle_alert_n_oe));
  c_fall: cover property ($fell(throttle_alert_n_oe));
  c_lp: cover property (!adapter_present && low_power_mode);
endmodule
bind dat_regs dat_regs_asserts #(.DEB_US(DEB_US), .HOLD_US(HOLD_US)) i_dat_regs_asserts (
  .sys_clk, .sys_rst, .discharge_ma, .adapter_present, .adapter_overcurrent, .low_sys_voltage,
  .low_power_mode, .system_power_monitor_en, .throttle_alert_n_oe, .active_threshold_ma,
  .comparator_ref_active);

// >>> verification/dat_smb_host.sv
// smbus host model issuing write-word and read-word transfers
`timescale 1ns/1ps
module dat_smb_host #(
  parameter logic [6:0] ADDR = 7'h5A
) (
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hp();
    repeat (4) @(negedge sys_clk);
  endtask
  // data moves one cycle after scl falls, never mistaken for start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    hp();
    scl = 1'b1;
    hp();
    r = sda;
    scl = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic start();
    sda_low = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b1;
    hp();
    scl = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b0;
    hp();
  endtask
  task automatic xfer(input logic [7:0] tx, input logic hb, output logic [7:0] rx,
                      output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(hb, a);
    ack = !a;
  endtask
  // low byte first, high byte commits the word
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] d, output logic ok);
    logic [7:0] r;
    logic [3:0] a;
    start();
    xfer({ADDR, 1'b0}, 1'b1, r, a[0]);
    xfer(cmd, 1'b1, r, a[1]);
    xfer(d[7:0], 1'b1, r, a[2]);
    xfer(d[15:8], 1'b1, r, a[3]);
    stop();
    ok = &a;
  endtask
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] d);
    logic a;
    start();
    xfer({ADDR, 1'b0}, 1'b1, d[7:0], a);
    xfer(cmd, 1'b1, d[7:0], a);
    start();
    xfer({ADDR, 1'b1}, 1'b1, d[7:0], a);
    xfer(8'hFF, 1'b0, d[7:0], a);
    xfer(8'hFF, 1'b1, d[15:8], a);
    stop();
  endtask
endmodule

// >>> verification/test_dat_regs.sv
// self-checking bench of the discharge alert threshold block
`timescale 1ns/1ps
`include "dat_params.svh"
module test_dat_regs;
  import dat_pkg::*;
  localparam logic [7:0]  CFG [5] = '{8'h39, 8'h3C, 8'h3D, 8'h4C, 8'h4E};
  localparam logic [15:0] LPT [4] = '{`DAT_LP_MA0, `DAT_LP_MA1, `DAT_LP_MA2, `DAT_LP_MA3};
  localparam int          DEBC[4] = '{100, 100, 200, 300};
  logic        sys_clk, sys_rst, scl, host_low, sda_o, sda_oe, ok;
  logic        adapter_present, adapter_overcurrent, low_sys_voltage, low_power_mode;
  logic        mon_en, rev_b, alert_o, alert_oe, ref_act;
  logic [15:0] discharge_ma, thr_ma, rd, v;
  logic [4:0]  buck, boost;
  int          bad_count, checks_done, d, h, c;
  wire         sda_w = !(sda_oe || host_low);
  dat_regs #(.DEB_US('{1, 1, 2, 3}), .HOLD_US('{1, 2, 3, 4, 5, 6, 7, 8})) i_dat_regs (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .discharge_ma(discharge_ma), .adapter_present(adapter_present),
    .adapter_overcurrent(adapter_overcurrent), .low_sys_voltage(low_sys_voltage),
    .low_power_mode(low_power_mode), .system_power_monitor_en(mon_en),
    .silicon_revision_b(rev_b), .throttle_alert_n_i(!alert_oe), .throttle_alert_n_o(alert_o),
    .throttle_alert_n_oe(alert_oe), .active_threshold_ma(thr_ma),
    .comparator_ref_active(ref_act), .buck_offset_half_mv(buck), .boost_offset_half_mv(boost));
  dat_smb_host #(.ADDR(`DAT_SMB_ADDR)) i_dat_smb_host (
    .sys_clk(sys_clk), .sda(sda_w), .scl(scl), .sda_low(host_low));
  function automatic logic [15:0] thr_exp(logic [15:0] x);
    return {2'b00, (x[13:8] > 6'h32) ? 6'h32 : x[13:8], 8'h00};
  endfunction
  // signed code in half millivolts, doubled on revision b
  function automatic logic [15:0] ofs_exp(logic [2:0] x, logic dbl);
    int s;
    s = (x[2] ? int'(x) - 8 : int'(x)) * (dbl ? 2 : 1);
    return {11'h0, 5'(s)};
  endfunction
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] x);
    i_dat_smb_host.write_word(cmd, x, ok);
    chk("ack", 16'(ok), 16'h1);
  endtask
  task automatic rdc(input logic [7:0] cmd, input logic [15:0] exp);
    i_dat_smb_host.read_word(cmd, rd);
    chk("read", rd, exp);
  endtask
  task automatic time_alert(input int deb, input int hold);
    int n;
    n = 0;
    while (alert_oe !== 1'b1 && n < 5000) begin
      @(negedge sys_clk);
      n++;
    end
    chk("rise", 16'(n >= deb && n <= deb + 6), 16'h1);
    discharge_ma = 16'h0000;
    {adapter_overcurrent, low_sys_voltage} = 2'b00;
    n = 0;
    while (alert_oe === 1'b1 && n < 30000) begin
      @(negedge sys_clk);
      n++;
    end
    chk("hold", 16'(n >= hold && n <= hold + 6), 16'h1);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    end_of_test();
  end
  initial begin
    {sys_rst, adapter_present} = 2'b11;
    {adapter_overcurrent, low_sys_voltage, low_power_mode, mon_en, rev_b} = '0;
    discharge_ma = 16'h0000;
    void'($urandom(87));
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) sys_rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("thr_out", thr_ma, 16'h1000);
    rdc(`DAT_CMD_THR, 16'h1000);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h32FF : (i == 2) ? 16'h3300 : 16'($urandom);
      wr(`DAT_CMD_THR, v);
      rdc(`DAT_CMD_THR, thr_exp(v));
      chk("thr_out", thr_ma, thr_exp(v));
    end
    for (int i = 0; i < 5; i++) begin
      v = 16'($urandom);
      wr(CFG[i], v);
      rdc(CFG[i], v);
    end
    rdc(8'h50, `DAT_RD_NONE);
    for (int i = 0; i < 8; i++) begin
      wr(`DAT_CMD_CFG0, {3'(i), 3'(i), 10'h000});
      for (int r = 0; r < 2; r++) begin
        rev_b = r[0];
        repeat (3) @(negedge sys_clk);
        chk("buck", {11'h0, buck}, ofs_exp(3'(i), r[0]));
        chk("boost", {11'h0, boost}, ofs_exp(3'(i), 1'b0));
      end
    end
    adapter_present = 1'b0;
    for (int m = 0; m < 2; m++) begin
      mon_en = m[0];
      repeat (3) @(negedge sys_clk);
      chk("ref", 16'(ref_act), 16'(m));
      i_dat_smb_host.read_word(`DAT_CMD_INFO, rd);
      chk("info_ref", 16'(rd[`DAT_INFO_REF]), 16'(m));
      chk("info_pin", 16'(rd[`DAT_INFO_PIN]), 16'h1);
    end
    low_power_mode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(`DAT_CMD_CFG0, {11'h000, 2'(i), 3'b000});
      chk("lp_thr", thr_ma, LPT[i]);
    end
    {low_power_mode, mon_en, adapter_present} = 3'b001;
    repeat (3) @(negedge sys_clk);
    chk("ref_ad", 16'(ref_act), 16'h1);
    for (int k = 0; k < 3; k++) begin
      d = (k == 0) ? 3 : int'($urandom % 4);
      h = (k == 0) ? 0 : int'($urandom % 8);
      c = 1 + int'($urandom % 50);
      wr(`DAT_CMD_CFG2, {5'h00, 2'(d), 3'(h), 6'h00});
      wr(`DAT_CMD_THR, {2'b00, 6'(c), 8'h00});
      discharge_ma = 16'(c * 256);
      repeat (400) @(negedge sys_clk);
      chk("alert_eq", 16'(alert_oe), 16'h0);
      discharge_ma = 16'(c * 256 + 1);
      time_alert(DEBC[d], (h + 1) * 100);
    end
    adapter_present = 1'b0;
    discharge_ma = 16'hFFFF;
    repeat (500) @(negedge sys_clk);
    chk("no_ref", 16'(alert_oe), 16'h0);
    mon_en = 1'b1;
    time_alert(DEBC[d], (h + 1) * 100);
    adapter_overcurrent = 1'b1;
    time_alert(DEBC[d], (h + 1) * 100);
    chk("od_low", {14'h0, alert_o, sda_o}, 16'h0000);
    low_sys_voltage = 1'b1;
    time_alert(1000, (h + 1) * 100);
    end_of_test();
  end
endmodule
